// ### efbm_top.sv
// Fuse bank manager: bank scan, parameter shadows and register port.
//
// Overview of operation
// - 768 fuse bits readable after reset release.
// - Six 128-bit banks, identical field layout.
// - Lower 80 bits fixed fields, 48 general.
// - Bluetooth address equals MAC address plus one.
// - Each bank burnable independently of others.
// - Shipped parts hold IQ trims in bank two.
// - Assigned MAC shipped in bank two.
//
// The register addresses and the strobed register port are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module efbm_top
	import efbm_pkg::*;
#(
	parameter logic [MAC_W-1:0] FACTORY_MAC = 48'h000000000000,
	parameter logic FACTORY_HAS_MAC = 1'b0,
	parameter logic [GAIN_W-1:0] FACTORY_IQ_GAIN = 6'h00,
	parameter logic [PHASE_W-1:0] FACTORY_IQ_PHASE = 6'h00
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [RA_W-1:0] i_addr,
	input wire logic [WORD_W-1:0] i_wr_data,
	input wire logic i_wr_en,
	input wire logic i_rd_en,
	output logic [WORD_W-1:0] o_rd_data,
	output logic o_params_ready,
	output logic o_bank_found,
	output logic [BANK_W-1:0] o_active_bank,
	output logic [MAC_W-1:0] o_mac_addr,
	output logic o_mac_valid,
	output logic [MAC_W-1:0] o_bt_addr,
	output logic [FREQ_W-1:0] o_freq_offset,
	output logic o_freq_valid,
	output logic [GAIN_W-1:0] o_iq_gain_trim,
	output logic o_iq_gain_valid,
	output logic [PHASE_W-1:0] o_iq_phase_trim,
	output logic o_iq_phase_valid,
	output logic [ADC_W-1:0] o_adc_trim,
	output logic o_adc_valid
);
	localparam int SCAN_MAX = 40;

	efbm_state_t state_ff, nxt_state;
	logic [IDX_W-1:0] idx_ff, nxt_idx;
	logic [BANKS-1:0] ok_map_ff;
	logic [BANK_W-1:0] bank_ff;
	logic found_ff;
	logic scan_pend_ff;
	logic [WORD_W-1:0] w0_ff, w1_ff, w2_ff;
	logic [FADDR_W-1:0] fuse_addr_ff;
	logic fetch_take_ff;
	logic [WORD_W-1:0] raw_ff;
	logic [WORD_W-1:0] mem_rdata;

	if (BANKS * BANK_BITS != FUSE_BITS || FIXED_BITS + GP_BITS != BANK_BITS)
	begin : g_bad_geometry
		$error("Fuse geometry constants are inconsistent.");
	end

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	// Word address of a word inside a bank.
	function automatic logic [FADDR_W-1:0] word_addr(input logic [BANK_W-1:0] bank, input logic [IDX_W-1:0] off);
		word_addr = {bank, off[1:0]};
	endfunction

	// Highest bank whose header is good; later banks supersede earlier ones.
	function automatic logic [BANK_W-1:0] top_bank(input logic [BANKS-1:0] map);
		top_bank = '0;
		for (int b = 0; b < BANKS; b++)
		begin
			if (map[b])
			begin
				top_bank = BANK_W'(b);
			end
		end
	endfunction

	// ----------------------------------------
	// Bus decode
	// ----------------------------------------
	wire idle = (state_ff == S_IDLE) && !scan_pend_ff;
	wire wr_ctrl = i_wr_en && (i_addr == REG_CTRL);
	wire wr_faddr = i_wr_en && (i_addr == REG_FUSE_ADDR) && idle;
	wire burn = i_wr_en && (i_addr == REG_FUSE_DATA) && idle;
	wire rescan = wr_ctrl && i_wr_data[CTRL_RESCAN];
	wire [FADDR_W-1:0] bus_faddr = i_wr_data[FADDR_W-1:0];

	// Memory address: scanner in its header and field read states, else the bus fetch or burn word.
	wire [FADDR_W-1:0] mem_addr = (state_ff == S_HDR_RD) ? word_addr(idx_ff[BANK_W-1:0], 3'h0) :
		(state_ff == S_FLD_RD) ? word_addr(bank_ff, idx_ff) :
		wr_faddr ? bus_faddr : fuse_addr_ff;

	efbm_fuse_mem #(
		.DEPTH(FUSE_WORDS),
		.FACTORY_MAC(FACTORY_MAC),
		.FACTORY_HAS_MAC(FACTORY_HAS_MAC),
		.FACTORY_IQ_GAIN(FACTORY_IQ_GAIN),
		.FACTORY_IQ_PHASE(FACTORY_IQ_PHASE)
	) u_fuse (
		.i_sys_clk(i_sys_clk),
		.i_rst(i_rst),
		.i_addr(mem_addr),
		.i_burn_en(burn),
		.i_burn_mask(i_wr_data),
		.o_rd_data(mem_rdata)
	);

	// ----------------------------------------
	// Scanner
	// ----------------------------------------
	// A bank counts only when burnt as used and not revoked.
	wire hdr_ok = mem_rdata[F_BANK_USED] && !mem_rdata[F_BANK_REVOKED];
	wire any_ok = |ok_map_ff;

	// Next state and index of the scan walk.
	always_comb
	begin
		nxt_state = state_ff;
		nxt_idx = idx_ff;
		unique case (state_ff)
			S_IDLE:
			begin
				if (scan_pend_ff)
				begin
					nxt_state = S_HDR_RD;
					nxt_idx = '0;
				end
			end
			S_HDR_RD: nxt_state = S_HDR_TAKE;
			S_HDR_TAKE:
			begin
				nxt_state = (idx_ff == IDX_W'(LAST_BANK)) ? S_PICK : S_HDR_RD;
				nxt_idx = idx_ff + 3'h1;
			end
			S_PICK:
			begin
				nxt_state = any_ok ? S_FLD_RD : S_LOAD;
				nxt_idx = '0;
			end
			S_FLD_RD: nxt_state = S_FLD_TAKE;
			S_FLD_TAKE:
			begin
				nxt_state = (idx_ff == LAST_FIELD_WORD) ? S_LOAD : S_FLD_RD;
				nxt_idx = idx_ff + 3'h1;
			end
			S_LOAD: nxt_state = S_IDLE;
			default: nxt_state = S_IDLE;
		endcase
	end

	// State, index and scan request; a scan runs after every reset release.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			state_ff <= S_IDLE;
			idx_ff <= '0;
			scan_pend_ff <= 1'b1;
		end
		else
		begin
			state_ff <= nxt_state;
			idx_ff <= nxt_idx;
			scan_pend_ff <= rescan || (scan_pend_ff && state_ff != S_IDLE);
		end
	end

	// Header map and the chosen bank.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			ok_map_ff <= '0;
			bank_ff <= '0;
			found_ff <= 1'b0;
		end
		else if (state_ff == S_HDR_TAKE)
		begin
			ok_map_ff[idx_ff] <= hdr_ok;
		end
		else if (state_ff == S_PICK)
		begin
			bank_ff <= top_bank(ok_map_ff);
			found_ff <= any_ok;
		end
	end

	// Fixed-field words of the chosen bank; the general-purpose word is never read.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			w0_ff <= '0;
			w1_ff <= '0;
			w2_ff <= '0;
		end
		else if (state_ff == S_FLD_TAKE)
		begin
			if (idx_ff == 3'h0) w0_ff <= mem_rdata;
			if (idx_ff == 3'h1) w1_ff <= mem_rdata;
			if (idx_ff == 3'h2) w2_ff <= mem_rdata;
		end
	end

	// ----------------------------------------
	// Parameter shadows
	// ----------------------------------------
	// A field is taken only when its own used bit is burnt.
	wire use_mac = found_ff && w0_ff[F_MAC_USED];
	wire use_freq = found_ff && w0_ff[F_FREQ_USED];
	wire use_gain = found_ff && w0_ff[F_GAIN_USED];
	wire use_phase = found_ff && w0_ff[F_PHASE_USED];
	wire use_adc = found_ff && w0_ff[F_ADC_USED];
	wire [MAC_W-1:0] nxt_mac = use_mac ? {w0_ff[F_MACHI_LSB +: MACHI_W], w1_ff} : '0;
	wire [MAC_W-1:0] nxt_bt = nxt_mac + BT_ADDR_STEP;
	wire load = (state_ff == S_LOAD);

	// Shadows update at the end of each scan; ready drops while one runs.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_params_ready <= 1'b0;
			o_bank_found <= 1'b0;
			o_active_bank <= '0;
			o_mac_addr <= '0;
			o_mac_valid <= 1'b0;
			o_bt_addr <= '0;
			o_freq_offset <= '0;
			o_freq_valid <= 1'b0;
			o_iq_gain_trim <= '0;
			o_iq_gain_valid <= 1'b0;
			o_iq_phase_trim <= '0;
			o_iq_phase_valid <= 1'b0;
			o_adc_trim <= '0;
			o_adc_valid <= 1'b0;
		end
		else if (load)
		begin
			o_params_ready <= 1'b1;
			o_bank_found <= found_ff;
			o_active_bank <= bank_ff;
			o_mac_addr <= nxt_mac;
			o_mac_valid <= use_mac;
			o_bt_addr <= nxt_bt;
			o_freq_offset <= use_freq ? w0_ff[F_FREQ_LSB +: FREQ_W] : '0;
			o_freq_valid <= use_freq;
			o_iq_gain_trim <= use_gain ? w2_ff[F_GAIN_LSB +: GAIN_W] : '0;
			o_iq_gain_valid <= use_gain;
			o_iq_phase_trim <= use_phase ? w2_ff[F_PHASE_LSB +: PHASE_W] : '0;
			o_iq_phase_valid <= use_phase;
			o_adc_trim <= use_adc ? w2_ff[F_ADC_LSB +: ADC_W] : '0;
			o_adc_valid <= use_adc;
		end
		else if (state_ff == S_HDR_RD)
		begin
			o_params_ready <= 1'b0;
		end
	end

	// ----------------------------------------
	// Raw fuse window and read port
	// ----------------------------------------
	// Writing the address fetches that word; the copy lands one edge later.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			fuse_addr_ff <= '0;
			fetch_take_ff <= 1'b0;
			raw_ff <= '0;
		end
		else
		begin
			if (wr_faddr) fuse_addr_ff <= bus_faddr;
			fetch_take_ff <= wr_faddr;
			if (fetch_take_ff) raw_ff <= mem_rdata;
		end
	end

	wire [WORD_W-1:0] status_word = WORD_W'({ok_map_ff, 3'h0, o_adc_valid, o_iq_phase_valid, o_iq_gain_valid,
		o_freq_valid, o_mac_valid, 1'b0, o_active_bank, 1'b0, o_bank_found, !idle, o_params_ready});
	wire [WORD_W-1:0] trim_word = WORD_W'({o_adc_trim, 2'h0, o_iq_phase_trim, 2'h0, o_iq_gain_trim, o_freq_offset});
	wire [WORD_W-1:0] rd_mux = (i_addr == REG_STATUS) ? status_word :
		(i_addr == REG_FUSE_ADDR) ? WORD_W'(fuse_addr_ff) :
		(i_addr == REG_FUSE_DATA) ? raw_ff :
		(i_addr == REG_MAC_LO) ? o_mac_addr[WORD_W-1:0] :
		(i_addr == REG_MAC_HI) ? WORD_W'(o_mac_addr[MAC_W-1:WORD_W]) :
		(i_addr == REG_BT_LO) ? o_bt_addr[WORD_W-1:0] :
		(i_addr == REG_BT_HI) ? WORD_W'(o_bt_addr[MAC_W-1:WORD_W]) :
		(i_addr == REG_TRIM) ? trim_word : '0;

	// Read data stand for one cycle after the strobe, zero otherwise.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rd_data <= '0;
		end
		else
		begin
			o_rd_data <= i_rd_en ? rd_mux : '0;
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (i_rst);

	sequence s_scan_start;
		(state_ff == S_IDLE) && scan_pend_ff;
	endsequence
	sequence s_scan_done;
		o_params_ready && (state_ff == S_IDLE);
	endsequence

	chk_scan_finishes: assert property (s_scan_start |-> ##[1:SCAN_MAX] s_scan_done)
		else $error("Fuse scan did not finish in time.");
	chk_rd_one_cycle: assert property (!$past(i_rd_en) |-> (o_rd_data == '0))
		else $error("Read data present without a read strobe.");
	chk_bank_in_range: assert property (o_active_bank <= LAST_BANK)
		else $error("Active bank outside the six banks.");
	chk_fixed_words_only: assert property ((state_ff == S_FLD_RD) |-> (idx_ff <= LAST_FIELD_WORD))
		else $error("Scanner read a general-purpose word.");
	chk_bt_addr_sum: assert property (o_params_ready |-> (o_bt_addr == o_mac_addr + BT_ADDR_STEP))
		else $error("Bluetooth address is not MAC plus one.");
	chk_pick_highest: assert property ($rose(o_params_ready) && o_bank_found |->
		ok_map_ff[o_active_bank] && ((ok_map_ff >> o_active_bank) == 6'h01))
		else $error("Chosen bank is not the highest good bank.");
	chk_unused_field: assert property (o_params_ready && !o_mac_valid |-> (o_mac_addr == '0))
		else $error("Unused MAC field was taken.");
endmodule
`default_nettype wire

// ### efbm_pkg.sv
// Constants, register map and fuse field layout for the fuse bank manager.
`default_nettype none
package efbm_pkg;
	// ----------------------------------------
	// Fuse array geometry
	// ----------------------------------------
	localparam int FUSE_BITS = 768;
	localparam int BANKS = 6;
	localparam int BANK_BITS = 128;
	localparam int WORD_W = 32;
	localparam int WORDS_PER_BANK = BANK_BITS / WORD_W;
	localparam int FUSE_WORDS = FUSE_BITS / WORD_W;
	localparam int FIXED_BITS = 80;
	localparam int GP_BITS = 48;
	localparam int FIELD_WORDS = 3;
	localparam int FADDR_W = 5;
	localparam int BANK_W = 3;
	localparam int IDX_W = 3;
	localparam logic [BANK_W-1:0] LAST_BANK = 3'h5;
	localparam logic [IDX_W-1:0] LAST_FIELD_WORD = 3'h2;

	// ----------------------------------------
	// Field layout inside a bank (word 0, word 1, word 2)
	// ----------------------------------------
	localparam int F_BANK_USED = 0;
	localparam int F_BANK_REVOKED = 1;
	localparam int F_MAC_USED = 2;
	localparam int F_FREQ_USED = 3;
	localparam int F_GAIN_USED = 4;
	localparam int F_PHASE_USED = 5;
	localparam int F_ADC_USED = 6;
	localparam int F_FREQ_LSB = 8;
	localparam int FREQ_W = 8;
	localparam int F_MACHI_LSB = 16;
	localparam int MACHI_W = 16;
	localparam int MAC_W = 48;
	localparam int F_GAIN_LSB = 0;
	localparam int GAIN_W = 6;
	localparam int F_PHASE_LSB = 6;
	localparam int PHASE_W = 6;
	localparam int F_ADC_LSB = 12;
	localparam int ADC_W = 4;
	localparam logic [MAC_W-1:0] BT_ADDR_STEP = 48'h000000000001;

	// ----------------------------------------
	// Register map
	// ----------------------------------------
	localparam int RA_W = 8;
	localparam logic [RA_W-1:0] REG_CTRL = 8'h00;
	localparam logic [RA_W-1:0] REG_STATUS = 8'h04;
	localparam logic [RA_W-1:0] REG_FUSE_ADDR = 8'h08;
	localparam logic [RA_W-1:0] REG_FUSE_DATA = 8'h0c;
	localparam logic [RA_W-1:0] REG_MAC_LO = 8'h10;
	localparam logic [RA_W-1:0] REG_MAC_HI = 8'h14;
	localparam logic [RA_W-1:0] REG_BT_LO = 8'h18;
	localparam logic [RA_W-1:0] REG_BT_HI = 8'h1c;
	localparam logic [RA_W-1:0] REG_TRIM = 8'h20;
	localparam int CTRL_RESCAN = 0;
	localparam int ST_READY = 0;
	localparam int ST_BUSY = 1;
	localparam int ST_FOUND = 2;
	localparam int ST_BANK_LSB = 4;
	localparam int ST_VALID_LSB = 8;
	localparam int ST_OKMAP_LSB = 16;
	localparam int TRIM_GAIN_LSB = 8;
	localparam int TRIM_PHASE_LSB = 16;
	localparam int TRIM_ADC_LSB = 24;

	// ----------------------------------------
	// Scanner states
	// ----------------------------------------
	typedef enum logic [2:0] {
		S_IDLE = 3'b000,
		S_HDR_RD = 3'b001,
		S_HDR_TAKE = 3'b010,
		S_PICK = 3'b011,
		S_FLD_RD = 3'b100,
		S_FLD_TAKE = 3'b101,
		S_LOAD = 3'b110
	} efbm_state_t;
endpackage
`default_nettype wire

// ### efbm_fuse_mem.sv
// One-time-programmable fuse array: burns only set bits, registered read data.
`timescale 1ns/10ps
`default_nettype none
module efbm_fuse_mem
	import efbm_pkg::*;
#(
	parameter int DEPTH = FUSE_WORDS,
	parameter logic [MAC_W-1:0] FACTORY_MAC = 48'h000000000000,
	parameter logic FACTORY_HAS_MAC = 1'b0,
	parameter logic [GAIN_W-1:0] FACTORY_IQ_GAIN = 6'h00,
	parameter logic [PHASE_W-1:0] FACTORY_IQ_PHASE = 6'h00
)
(
	input wire logic i_sys_clk,
	input wire logic i_rst,
	input wire logic [FADDR_W-1:0] i_addr,
	input wire logic i_burn_en,
	input wire logic [WORD_W-1:0] i_burn_mask,
	output logic [WORD_W-1:0] o_rd_data
);
	typedef logic [WORD_W-1:0] efbm_image_t [DEPTH];

	if (DEPTH != BANKS * WORDS_PER_BANK || DEPTH > 2 ** FADDR_W)
	begin : g_bad_depth
		$error("Fuse depth does not match the bank geometry.");
	end

	// Shipped image: banks 0 and 1 retired, bank 2 valid with gain and phase trims, optional MAC.
	function automatic efbm_image_t ship_image();
		efbm_image_t img;
		for (int w = 0; w < DEPTH; w++)
		begin
			img[w] = '0;
		end
		img[0][F_BANK_REVOKED] = 1'b1;
		img[WORDS_PER_BANK][F_BANK_REVOKED] = 1'b1;
		img[2 * WORDS_PER_BANK][F_BANK_USED] = 1'b1;
		img[2 * WORDS_PER_BANK][F_GAIN_USED] = 1'b1;
		img[2 * WORDS_PER_BANK][F_PHASE_USED] = 1'b1;
		img[2 * WORDS_PER_BANK + 2][F_GAIN_LSB +: GAIN_W] = FACTORY_IQ_GAIN;
		img[2 * WORDS_PER_BANK + 2][F_PHASE_LSB +: PHASE_W] = FACTORY_IQ_PHASE;
		if (FACTORY_HAS_MAC)
		begin
			img[2 * WORDS_PER_BANK][F_MAC_USED] = 1'b1;
			img[2 * WORDS_PER_BANK][F_MACHI_LSB +: MACHI_W] = FACTORY_MAC[MAC_W-1:WORD_W];
			img[2 * WORDS_PER_BANK + 1] = FACTORY_MAC[WORD_W-1:0];
		end
		return img;
	endfunction

	// The array starts from the shipped image, so the burn process is its only writer.
	efbm_image_t fuse_ff = ship_image();
	logic [WORD_W-1:0] nxt_word;

	// A burn can only add ones; each word, hence each bank, is burnt on its own.
	assign nxt_word = fuse_ff[i_addr] | i_burn_mask;

	// Array update, no reset: the fuses keep their state.
	always_ff @(posedge i_sys_clk)
	begin
		if (i_burn_en)
		begin
			fuse_ff[i_addr] <= nxt_word;
		end
	end

	// Read data register.
	always_ff @(posedge i_sys_clk or posedge i_rst)
	begin
		if (i_rst)
		begin
			o_rd_data <= '0;
		end
		else
		begin
			o_rd_data <= fuse_ff[i_addr];
		end
	end

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	chk_burn_keeps_ones: assert property (@(posedge i_sys_clk) disable iff (i_rst)
		i_burn_en |=> (fuse_ff[$past(i_addr)] == ($past(fuse_ff[i_addr]) | $past(i_burn_mask))))
		else $error("Burn did not OR the mask into the fuse word.");
endmodule
`default_nettype wire

// ### efbm_agent.sv
// Fuse programming agent model: register-port master that burns and fetches fuse words.
`timescale 1ns/10ps
`default_nettype none
module efbm_agent
	import efbm_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic [WORD_W-1:0] i_rd_data,
	output logic [RA_W-1:0] o_addr,
	output logic [WORD_W-1:0] o_wr_data,
	output logic o_wr_en,
	output logic o_rd_en
);
	// --------------------------------------
	// Bus cycles
	// --------------------------------------
	// The bus is idle from time zero.
	initial
	begin
		o_addr = 8'h00;
		o_wr_data = 32'h00000000;
		o_wr_en = 1'b0;
		o_rd_en = 1'b0;
	end

	// One-cycle write; data is inverted afterwards so stale data never looks valid.
	task automatic bus_wr(input logic [RA_W-1:0] addr, input logic [WORD_W-1:0] data);
		@(posedge i_sys_clk);
		o_addr <= addr;
		o_wr_data <= data;
		o_wr_en <= 1'b1;
		@(posedge i_sys_clk);
		o_wr_en <= 1'b0;
		o_wr_data <= ~data;
	endtask

	// One-cycle read; the answer is taken in the cycle after the strobe.
	task automatic bus_rd(input logic [RA_W-1:0] addr, output logic [WORD_W-1:0] data);
		@(posedge i_sys_clk);
		o_addr <= addr;
		o_rd_en <= 1'b1;
		@(posedge i_sys_clk);
		o_rd_en <= 1'b0;
		#1;
		data = i_rd_data;
	endtask

	// --------------------------------------
	// Fuse operations
	// --------------------------------------
	// Burn a mask into one fuse word; only set bits take effect.
	task automatic burn(input logic [FADDR_W-1:0] word, input logic [WORD_W-1:0] mask);
		bus_wr(REG_FUSE_ADDR, {27'h0000000, word});
		bus_wr(REG_FUSE_DATA, mask);
	endtask

	// Fetch one raw fuse word.
	task automatic fetch(input logic [FADDR_W-1:0] word, output logic [WORD_W-1:0] data);
		bus_wr(REG_FUSE_ADDR, {27'h0000000, word});
		bus_rd(REG_FUSE_DATA, data);
	endtask

	// Move parameters to a fresh bank: retire, copy with used flags, then validate last.
	task automatic replace_bank(input logic [BANK_W-1:0] old_bank, input logic [BANK_W-1:0] new_bank,
		input logic [MAC_W-1:0] mac, input logic [FREQ_W-1:0] freq, input logic [GAIN_W-1:0] gain,
		input logic [PHASE_W-1:0] phase);
		logic [FADDR_W-1:0] base;
		base = {new_bank, 2'b00};
		if (new_bank < 3'h2)
			return;
		burn({old_bank, 2'b00}, 32'h00000002);
		burn(base + 5'h01, mac[31:0]);
		burn(base + 5'h02, {20'h00000, phase, gain});
		burn(base, {mac[47:32], freq, 8'h3c});
		burn(base, 32'h00000001);
	endtask
endmodule
`default_nettype wire

// ### tb_top.sv
// Self-checking testbench for the fuse bank manager.
`timescale 1ns/10ps
`default_nettype none
module tb_top
	import efbm_pkg::*;
;
	localparam logic [MAC_W-1:0] SHIP_MAC = 48'h0a1b2c3d4eff;
	localparam logic [MAC_W-1:0] NEW_MAC = 48'h00112233ffff;
	localparam int SCAN_BOUND = 40;
	logic i_sys_clk;
	logic i_rst;
	logic [RA_W-1:0] bus_addr;
	logic [WORD_W-1:0] bus_wdata;
	logic [WORD_W-1:0] rd_data;
	logic bus_wr_en;
	logic bus_rd_en;
	logic params_ready;
	logic bank_found;
	logic [BANK_W-1:0] active_bank;
	logic [MAC_W-1:0] mac_addr;
	logic mac_valid;
	logic [MAC_W-1:0] bt_addr;
	logic [FREQ_W-1:0] freq_offset;
	logic freq_valid;
	logic [GAIN_W-1:0] gain_trim;
	logic gain_valid;
	logic [PHASE_W-1:0] phase_trim;
	logic phase_valid;
	logic [ADC_W-1:0] adc_trim;
	logic adc_valid;
	logic [WORD_W-1:0] word;
	int bad_count;
	int n_compared;
	int n;

	efbm_top #(.FACTORY_MAC(SHIP_MAC), .FACTORY_HAS_MAC(1'b1), .FACTORY_IQ_GAIN(6'h2a),
		.FACTORY_IQ_PHASE(6'h15)) uut (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_addr(bus_addr),
		.i_wr_data(bus_wdata), .i_wr_en(bus_wr_en), .i_rd_en(bus_rd_en), .o_rd_data(rd_data),
		.o_params_ready(params_ready), .o_bank_found(bank_found), .o_active_bank(active_bank),
		.o_mac_addr(mac_addr), .o_mac_valid(mac_valid), .o_bt_addr(bt_addr), .o_freq_offset(freq_offset),
		.o_freq_valid(freq_valid), .o_iq_gain_trim(gain_trim), .o_iq_gain_valid(gain_valid),
		.o_iq_phase_trim(phase_trim), .o_iq_phase_valid(phase_valid), .o_adc_trim(adc_trim),
		.o_adc_valid(adc_valid));

	efbm_agent u_agent (.i_sys_clk(i_sys_clk), .i_rd_data(rd_data), .o_addr(bus_addr),
		.o_wr_data(bus_wdata), .o_wr_en(bus_wr_en), .o_rd_en(bus_rd_en));

	// --------------------------------------
	// Clock
	// --------------------------------------
	// 50 MHz system clock.
	initial
	begin
		i_sys_clk = 1'b0;
		forever #10 i_sys_clk = ~i_sys_clk;
	end

	// --------------------------------------
	// Helpers
	// --------------------------------------
	// Compare a seen value against the expectation and count it.
	task automatic check(input string name, input logic [MAC_W-1:0] seen, input logic [MAC_W-1:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			bad_count++;
			$display("ERROR %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Print the verdict and stop.
	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// Wait for the ready flag to reach a level, counting edges; a hang ends the run.
	task automatic wait_ready(input logic level, output int edges);
		edges = 0;
		while (params_ready !== level)
		begin
			@(posedge i_sys_clk);
			#1;
			edges++;
			if (edges > SCAN_BOUND)
			begin
				bad_count++;
				$display("ERROR params_ready expected %h seen timeout", level);
				print_verdict();
			end
		end
	endtask

	// Request a rescan and wait for it to finish.
	task automatic rescan();
		u_agent.bus_wr(REG_CTRL, 32'h00000001);
		wait_ready(1'b0, n);
		wait_ready(1'b1, n);
	endtask

	// Read a register and compare.
	task automatic reg_check(input string name, input logic [RA_W-1:0] addr, input logic [WORD_W-1:0] exp);
		u_agent.bus_rd(addr, word);
		check(name, {16'h0000, word}, {16'h0000, exp});
	endtask

	// --------------------------------------
	// Main sequence
	// --------------------------------------
	// Shipped image, register reads, bank replacement, partial bank, second reset, no good bank.
	initial
	begin
		bad_count = 0;
		n_compared = 0;
		i_rst = 1'b1;
		repeat (20) @(posedge i_sys_clk);
		check("ready_in_reset", params_ready, 1'b0);
		i_rst <= 1'b0;
		wait_ready(1'b1, n);
		check("scan_edges", n, 21);
		check("active_bank", active_bank, 3'h2);
		check("mac", mac_addr, SHIP_MAC);
		check("bt_addr", bt_addr, SHIP_MAC + 48'h1);
		check("gain", {gain_valid, gain_trim}, 7'h6a);
		check("phase", {phase_valid, phase_trim}, 7'h55);
		check("freq_adc", {freq_valid, adc_valid, freq_offset, adc_trim}, 14'h0000);
		reg_check("status", REG_STATUS, 32'h00040d25);
		reg_check("mac_lo", REG_MAC_LO, 32'h2c3d4eff);
		reg_check("mac_hi", REG_MAC_HI, 32'h00000a1b);
		reg_check("bt_lo", REG_BT_LO, 32'h2c3d4f00);
		reg_check("bt_hi", REG_BT_HI, 32'h00000a1b);
		reg_check("trim", REG_TRIM, 32'h00152a00);
		reg_check("ctrl", REG_CTRL, 32'h00000000);
		reg_check("unmapped", 8'h24, 32'h00000000);
		u_agent.fetch(5'h00, word);
		check("bank0_w0", word, 32'h00000002);
		u_agent.fetch(5'h09, word);
		check("bank2_w1", word, 32'h2c3d4eff);
		u_agent.fetch(5'h17, word);
		check("last_word", word, 32'h00000000);
		u_agent.burn(5'h0f, 32'hffffffff);
		u_agent.burn(5'h0e, 32'hffff0000);
		u_agent.replace_bank(3'h2, 3'h3, NEW_MAC, 8'h5a, 6'h2a, 6'h15);
		u_agent.fetch(5'h08, word);
		check("bank2_revoked", word[1], 1'b1);
		u_agent.fetch(5'h0c, word);
		check("bank3_w0", word, 32'h00115a3d);
		rescan();
		check("upd_bank", active_bank, 3'h3);
		check("upd_mac", mac_addr, NEW_MAC);
		check("upd_bt", bt_addr, 48'h001122340000);
		check("upd_trims", {freq_offset, gain_trim, phase_trim}, 20'h5aa95);
		u_agent.burn(5'h10, 32'h00000050);
		u_agent.burn(5'h11, 32'hdeadbeef);
		u_agent.burn(5'h12, 32'h0000a007);
		rescan();
		check("unused_bank", active_bank, 3'h3);
		u_agent.burn(5'h10, 32'h00000001);
		rescan();
		check("bank4", active_bank, 3'h4);
		check("bank4_mac", {mac_valid, mac_addr}, 49'h0);
		check("bank4_bt", bt_addr, 48'h000000000001);
		check("bank4_gain", {gain_valid, gain_trim, phase_valid}, 8'h8e);
		check("bank4_adc", {adc_valid, adc_trim}, 5'h1a);
		@(posedge i_sys_clk);
		i_rst <= 1'b1;
		repeat (2) @(posedge i_sys_clk);
		check("ready_reset2", {params_ready, active_bank}, 4'h0);
		i_rst <= 1'b0;
		wait_ready(1'b1, n);
		check("scan_edges2", n, 21);
		check("kept_bank", active_bank, 3'h4);
		u_agent.burn(5'h0c, 32'h00000002);
		u_agent.burn(5'h10, 32'h00000002);
		rescan();
		check("none_found", {bank_found, active_bank}, 4'h0);
		check("none_gain", {gain_valid, gain_trim}, 7'h00);
		print_verdict();
	end
endmodule
`default_nettype wire
